// File: rtl/nic_dma_params.svh
// Timing counts and fixed encodings of the bus DMA and port control block.
`ifndef NIC_DMA_PARAMS_SVH
`define NIC_DMA_PARAMS_SVH

// Bus clocks per transfer cycle, and the index of its last clock.
`define XFER_BUS_CLOCKS 4
`define LAST_PHASE      2'h3
// Bus clocks spent synchronising to a host register access.
`define SYNC_BUS_CLOCKS 4'h2
// Address and count step per transfer in byte and word mode.
`define BYTE_STEP       16'h0001
`define WORD_STEP       16'h0002
// Local burst length in transfers, word mode, per burst select code.
`define BURST_W0        4'h1
`define BURST_W1        4'h2
`define BURST_W2        4'h4
`define BURST_W3        4'h6
// Local burst length in transfers, byte mode, per burst select code.
`define BURST_B0        4'h2
`define BURST_B1        4'h4
`define BURST_B2        4'h8
`define BURST_B3        4'hc

`endif

// File: rtl/nic_dma_pkg.sv
// Types shared by the bus DMA and port control block.
package nic_dma_pkg;

    typedef enum logic [1:0] {
        st_idle,
        st_arb,
        st_upper,
        st_xfer
    } seq_state_t;

    typedef enum logic {
        own_local,
        own_remote
    } owner_t;

endpackage : nic_dma_pkg

// File: rtl/slave_port.sv
// Host register slave access with held-off acknowledge.
`timescale 1ns/100ps
`include "nic_dma_params.svh"
module slave_port (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       bus_tick,
    // Host slave pins
    input  wire logic       chip_select_n,
    input  wire logic       slave_read_strobe_n,
    input  wire logic       slave_write_strobe_n,
    input  wire logic       address_latch_strobe_n,
    input  wire logic [3:0] register_select_lines,
    input  wire logic       mux_addr_mode,
    output logic            slave_ack_n,
    // Register file side
    input  wire logic       master_busy,
    output logic [3:0]      reg_index,
    output logic            reg_rd_pulse,
    output logic            reg_wr_pulse,
    output logic            slave_wait
);
    logic       access;
    logic [3:0] ras_q;
    logic [3:0] sync_q;
    logic       ack_q;

    assign access      = !chip_select_n &&
                         (!slave_read_strobe_n || !slave_write_strobe_n);
    assign slave_ack_n = !ack_q;
    assign slave_wait  = access && !ack_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ras_q <= 4'h0;
        end else if (!address_latch_strobe_n) begin
            ras_q <= register_select_lines; // RULE19
        end
    end

    // The acknowledge waits for the master tenure to end, then for the
    // synchronising clocks; a short chip select gap can upset this count.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_q       <= 4'h0;
            ack_q        <= 1'b0;
            reg_index    <= 4'h0;
            reg_rd_pulse <= 1'b0;
            reg_wr_pulse <= 1'b0;
        end else begin
            reg_rd_pulse <= 1'b0;
            reg_wr_pulse <= 1'b0;
            if (!access) begin
                sync_q <= 4'h0;
                ack_q  <= 1'b0;
            end else if (master_busy && !ack_q) begin
                sync_q <= 4'h0; // RULE20
            end else if (sync_q < `SYNC_BUS_CLOCKS) begin
                if (bus_tick) begin
                    sync_q <= sync_q + 4'h1; // RULE22
                end
            end else if (!ack_q) begin
                ack_q        <= 1'b1; // RULE18
                reg_index    <= mux_addr_mode ? ras_q
                                              : register_select_lines;
                reg_rd_pulse <= !slave_read_strobe_n;
                reg_wr_pulse <= !slave_write_strobe_n;
            end
        end
    end

    a_ack_held_master: assert property (@(posedge core_clk) // RULE20
        disable iff (!rst_n)
        (access && master_busy && !ack_q) |=> !ack_q)
        else $error("acknowledge given while master");

    a_ack_after_sync: assert property (@(posedge core_clk) // RULE22
        disable iff (!rst_n)
        (access && !ack_q && sync_q < `SYNC_BUS_CLOCKS) |=> !ack_q)
        else $error("acknowledge before synchronising");

endmodule : slave_port

// File: rtl/nic_bus_dma.sv
// System bus DMA sequencer, remote port latch and slave access control.
// Overview of operation
// RULE1 - Address 16 or 32 bit, data 8 or 16
// RULE2 - Each transfer cycle lasts four bus clocks
// RULE3 - 32-bit mode adds upper address cycle per burst
// RULE4 - Upper address is the fixed page register
// RULE5 - Granted local burst runs exact length, releases
// RULE6 - Burst 1,2,4,6 words or 2,4,8,12 bytes
// RULE7 - Next local burst waits for FIFO threshold
// RULE8 - Grant withdrawn mid-transfer aborts the burst
// RULE9 - Local beats remote; remote re-arbitrates afterwards
// RULE10 - FIFO need during remote keeps request, appends
// RULE11 - Local to remote drops then raises request
// RULE12 - Remote arbitrates per transfer, one direction
// RULE13 - Remote read fills latch, steps address, count
// RULE14 - Port request after fill; read strobe acknowledges
// RULE15 - Request dropped per remote transfer; local holds off
// RULE16 - Remote write request removed on write strobe
// RULE17 - Remote write stores latch, steps, re-requests
// RULE18 - Chip select gives byte-wide register slave access
// RULE19 - Address latch strobe captures register select
// RULE20 - Acknowledge held while master, then synchronise
// RULE21 - Host spaces chip selects four bus clocks
// RULE22 - Whole bus clocks inserted before acknowledge
// RULE23 - Missed grant setup slips start four clocks
// RULE24 - Remote tenure single transfer; local tenure bursts
// RULE25 - Remote stops requesting when count reaches zero
`timescale 1ns/100ps
`include "nic_dma_params.svh"
module nic_bus_dma
    import nic_dma_pkg::*;
#(
    parameter int FIFO_DEPTH = 16,
    parameter int BUS_DIV    = 1
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // Data configuration
    input  wire logic        addr32_mode,
    input  wire logic        word_mode,
    input  wire logic [1:0]  burst_sel,
    input  wire logic [4:0]  fifo_threshold,
    // Local DMA work from the packet logic
    input  wire logic        local_pending,
    input  wire logic        local_to_fifo,
    input  wire logic [15:0] local_addr,
    output logic             local_advance,
    // FIFO side
    input  wire logic [4:0]  fifo_level,
    input  wire logic [15:0] fifo_rdata,
    output logic             fifo_pop,
    output logic             fifo_push,
    output logic [15:0]      fifo_wdata,
    // Remote DMA setup and status
    input  wire logic [7:0]  remote_start_addr_low,
    input  wire logic [7:0]  remote_start_addr_high,
    input  wire logic [15:0] remote_offset_init,
    input  wire logic [15:0] remote_byte_count,
    input  wire logic        remote_start,
    input  wire logic        remote_write,
    output logic [15:0]      remote_addr,
    output logic [15:0]      remote_count_left,
    output logic             remote_done,
    // Bus arbitration
    output logic             bus_request_out,
    input  wire logic        bus_grant,
    // Buffer memory bus
    output logic [15:0]      mem_addr,
    output logic             mem_addr_oe,
    output logic             mem_addr_strobe,
    output logic             upper_address_cycle,
    output logic             mem_rd,
    output logic             mem_wr,
    output logic [15:0]      mem_wdata,
    output logic             mem_wdata_oe,
    input  wire logic [15:0] mem_rdata,
    // Host I/O port
    output logic             port_request,
    input  wire logic        port_read_strobe,
    input  wire logic        port_write_strobe,
    input  wire logic [15:0] port_wdata,
    output logic [15:0]      port_rdata,
    // Host register slave
    input  wire logic        chip_select_n,
    input  wire logic        slave_read_strobe_n,
    input  wire logic        slave_write_strobe_n,
    input  wire logic        address_latch_strobe_n,
    input  wire logic [3:0]  register_select_lines,
    input  wire logic        mux_addr_mode,
    output logic             slave_ack_n,
    output logic [3:0]       reg_index,
    output logic             reg_rd_pulse,
    output logic             reg_wr_pulse
);
    localparam logic [4:0] DEPTH = 5'(FIFO_DEPTH);

    generate
        if (FIFO_DEPTH < 2 || FIFO_DEPTH > 31 || BUS_DIV < 1 ||
            BUS_DIV > 255) begin : g_bad_param
            $error("unsupported FIFO depth or bus divider");
        end
    endgenerate

    seq_state_t  state_q;
    owner_t      own_q;
    logic [1:0]  tph_q;
    logic [3:0]  left_q;
    logic [7:0]  div_q;
    logic        tick;
    logic        slot_end;
    logic        xfer_end;
    logic        fifo_ok;
    logic        local_need;
    logic        remote_need;
    logic        is_read;
    logic        slave_wait;
    logic        rem_active_q;
    logic        latch_full_q;
    logic [15:0] step;
    logic [3:0]  burst_len;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // Bus clock enable; with BUS_DIV of one every core clock is a bus clock.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 8'h00;
        end else if (tick) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    assign tick     = (div_q == 8'(BUS_DIV - 1));
    assign slot_end = tick && (tph_q == `LAST_PHASE); // RULE2
    assign xfer_end = (state_q == st_xfer) && slot_end && bus_grant;
    assign step     = word_mode ? `WORD_STEP : `BYTE_STEP; // RULE1

    always_comb begin
        unique case ({word_mode, burst_sel}) // RULE6
            3'h4:    burst_len = `BURST_W0;
            3'h5:    burst_len = `BURST_W1;
            3'h6:    burst_len = `BURST_W2;
            3'h7:    burst_len = `BURST_W3;
            3'h0:    burst_len = `BURST_B0;
            3'h1:    burst_len = `BURST_B1;
            3'h2:    burst_len = `BURST_B2;
            default: burst_len = `BURST_B3;
        endcase
    end

    // Filling the FIFO waits for enough room, draining it for enough data.
    assign fifo_ok     = local_to_fifo ? ((DEPTH - fifo_level) > fifo_threshold)
                                       : (fifo_level > fifo_threshold); // RULE7
    assign local_need  = local_pending && fifo_ok;
    assign remote_need = rem_active_q && (remote_count_left != 16'h0000) &&
                         (remote_write ? latch_full_q : !latch_full_q);
    assign is_read     = (own_q == own_local) ? local_to_fifo : !remote_write;

    // Sequencer: arbitration, upper address cycle, transfer cycles.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= st_idle;
            own_q   <= own_local;
            tph_q   <= 2'h0;
            left_q  <= 4'h0;
        end else begin
            if (tick) begin
                tph_q <= tph_q + 2'h1;
            end
            unique case (state_q)
                st_idle: begin
                    tph_q <= 2'h0;
                    if (tick && !slave_wait) begin
                        if (local_need) begin
                            state_q <= st_arb; // RULE9
                            own_q   <= own_local;
                            left_q  <= burst_len;
                        end else if (remote_need) begin
                            state_q <= st_arb; // RULE15
                            own_q   <= own_remote;
                            left_q  <= 4'h1;
                        end
                    end
                end
                st_arb: begin
                    // A grant missing at the slot end costs one more slot.
                    if (slot_end && bus_grant) begin // RULE23
                        state_q <= addr32_mode ? st_upper : st_xfer; // RULE3
                    end
                end
                st_upper: begin
                    if (!bus_grant) begin
                        state_q <= st_idle; // RULE8
                    end else if (slot_end) begin
                        state_q <= st_xfer;
                    end
                end
                st_xfer: begin
                    if (!bus_grant) begin
                        state_q <= st_idle; // RULE8
                    end else if (slot_end) begin
                        if (own_q == own_remote && local_need) begin
                            own_q   <= own_local; // RULE10
                            left_q  <= burst_len;
                            state_q <= addr32_mode ? st_upper : st_xfer;
                        end else if (own_q == own_remote) begin
                            state_q <= st_idle; // RULE24
                        end else if (left_q == 4'h1) begin
                            state_q <= st_idle; // RULE5
                        end else begin
                            left_q <= left_q - 4'h1;
                        end
                    end
                end
            endcase
        end
    end

    // Idle always sits at least one clock, so every local tenure ends
    // with the request low before a remote one may raise it.
    assign bus_request_out = (state_q != st_idle); // RULE11
    assign upper_address_cycle = (state_q == st_upper);
    assign mem_addr_oe     = (state_q == st_upper) || (state_q == st_xfer);
    assign mem_addr_strobe = mem_addr_oe && (tph_q == 2'h0);
    assign mem_addr = (state_q == st_upper) ?
                      {remote_start_addr_high, remote_start_addr_low} // RULE4
                    : ((own_q == own_local) ? local_addr : remote_addr);
    assign mem_rd       = (state_q == st_xfer) && is_read && (tph_q != 2'h0);
    assign mem_wr       = (state_q == st_xfer) && !is_read &&
                          (tph_q != 2'h0);
    assign mem_wdata_oe = mem_wr;
    assign mem_wdata    = (own_q == own_local) ? fifo_rdata : port_rdata;

    // Local data movement; a FIFO word is popped only once it is stored.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fifo_push     <= 1'b0;
            fifo_pop      <= 1'b0;
            fifo_wdata    <= 16'h0000;
            local_advance <= 1'b0;
        end else begin
            fifo_push     <= xfer_end && own_q == own_local && is_read;
            fifo_pop      <= xfer_end && own_q == own_local && !is_read;
            local_advance <= xfer_end && own_q == own_local;
            if (xfer_end && own_q == own_local && is_read) begin
                fifo_wdata <= mem_rdata;
            end
        end
    end

    // Remote address and byte count.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            remote_addr       <= 16'h0000;
            remote_count_left <= 16'h0000;
        end else if (remote_start) begin
            remote_addr       <= remote_offset_init;
            remote_count_left <= remote_byte_count;
        end else if (xfer_end && own_q == own_remote) begin
            remote_addr <= remote_addr + step; // RULE13 RULE17
            remote_count_left <= (remote_count_left > step) ?
                                 remote_count_left - step : 16'h0000;
        end
    end

    // Remote run flag; it ends once the count is spent and the latch idle.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rem_active_q <= 1'b0;
        end else if (remote_start) begin
            rem_active_q <= (remote_byte_count != 16'h0000);
        end else if (remote_count_left == 16'h0000 && !latch_full_q) begin
            rem_active_q <= 1'b0; // RULE25
        end
    end

    assign remote_done = !rem_active_q;

    // Port latch. Only one direction is live at a time, chosen by
    // remote_write; changing it mid-run is not supported.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            port_rdata   <= 16'h0000;
            latch_full_q <= 1'b0;
        end else if (!remote_write) begin
            if (xfer_end && own_q == own_remote) begin
                port_rdata   <= mem_rdata; // RULE13
                latch_full_q <= 1'b1;
            end else if (port_read_strobe && latch_full_q) begin
                latch_full_q <= 1'b0; // RULE14
            end
        end else begin
            if (xfer_end && own_q == own_remote) begin
                latch_full_q <= 1'b0; // RULE17
            end else if (port_write_strobe && port_request) begin
                port_rdata   <= port_wdata;
                latch_full_q <= 1'b1; // RULE16
            end
        end
    end

    assign port_request = rem_active_q &&
        (remote_write ? (!latch_full_q && remote_count_left != 16'h0000)
                      : latch_full_q); // RULE12

    slave_port u_slave (
        .core_clk               (core_clk),
        .rst_n                  (rst_n),
        .bus_tick               (tick),
        .chip_select_n          (chip_select_n),
        .slave_read_strobe_n    (slave_read_strobe_n),
        .slave_write_strobe_n   (slave_write_strobe_n),
        .address_latch_strobe_n (address_latch_strobe_n),
        .register_select_lines  (register_select_lines),
        .mux_addr_mode          (mux_addr_mode),
        .slave_ack_n            (slave_ack_n),
        .master_busy            (bus_request_out),
        .reg_index              (reg_index),
        .reg_rd_pulse           (reg_rd_pulse),
        .reg_wr_pulse           (reg_wr_pulse),
        .slave_wait             (slave_wait)
    );

    a_upper_first: assert property ( // RULE3
        (state_q == st_arb && slot_end && bus_grant && addr32_mode)
        |=> upper_address_cycle && mem_addr ==
            {remote_start_addr_high, remote_start_addr_low})
        else $error("upper address cycle missing");

    a_grant_abort: assert property ( // RULE8
        (mem_addr_oe && !bus_grant) |=> !bus_request_out)
        else $error("burst not aborted on lost grant");

    a_local_first: assert property ( // RULE9
        (state_q == st_idle && tick && !slave_wait && local_need)
        |=> state_q == st_arb && own_q == own_local)
        else $error("remote chosen over local");

    a_append_burst: assert property ( // RULE10
        (xfer_end && own_q == own_remote && local_need)
        |=> bus_request_out && own_q == own_local)
        else $error("local burst not appended");

    a_remote_drop: assert property ( // RULE15
        (xfer_end && own_q == own_remote && !local_need)
        |=> !bus_request_out ##1 1'b1)
        else $error("request held after remote transfer");

    a_burst_exact: assert property ( // RULE5
        (xfer_end && own_q == own_local && left_q == 4'h1)
        |=> !bus_request_out)
        else $error("local burst length wrong");

    a_threshold_gate: assert property ( // RULE7
        (state_q == st_arb && $past(state_q) == st_idle &&
         own_q == own_local) |-> $past(fifo_ok))
        else $error("burst started below threshold");

    a_count_step: assert property ( // RULE13
        (xfer_end && own_q == own_remote && !remote_start &&
         remote_count_left > step)
        |=> remote_count_left == $past(remote_count_left) - $past(step)
            && remote_addr == $past(remote_addr) + $past(step))
        else $error("remote address or count not stepped");

    a_port_req_off: assert property ( // RULE16
        (remote_write && port_write_strobe && port_request)
        |=> !port_request)
        else $error("port request kept after host write");

    a_phase_four: assert property ( // RULE2
        ($rose(state_q == st_xfer) && BUS_DIV == 1)
        |-> mem_addr_strobe ##1 mem_addr_oe [*3])
        else $error("transfer cycle not four clocks");

endmodule : nic_bus_dma

// File: test/bus_partner.sv
// Arbiter and buffer memory model on the far side of the system bus.
`timescale 1ns/100ps
module bus_partner (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // Arbitration
    input  wire logic        bus_request_out,
    input  wire logic        slow,
    input  wire logic        cut,
    output logic             bus_grant,
    // Buffer memory
    input  wire logic [15:0] mem_addr,
    input  wire logic        mem_rd,
    output logic [15:0]      mem_rdata
);
    logic [3:0] wait_q;

    // A slow arbiter misses the first slot so the start has to slip.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_q    <= 4'h0;
            bus_grant <= 1'b0;
        end else begin
            wait_q    <= bus_request_out ? {wait_q[2:0], 1'b1} : 4'h0;
            bus_grant <= bus_request_out && !cut && (!slow || wait_q[3]);
        end
    end

    // Off a read the data bus shows the inverse, never a stale match.
    assign mem_rdata = mem_rd ? mem_addr ^ 16'h5a3c : ~(mem_addr ^ 16'h5a3c);
endmodule : bus_partner

// File: test/nic_bus_dma_tb_top.sv
// Self-checking bench for the bus DMA and port control block.
`timescale 1ns/100ps
module nic_bus_dma_tb_top;
    logic        core_clk, rst_n, addr32_mode, word_mode, local_pending, cut;
    logic        local_to_fifo, local_advance, fifo_pop, fifo_push, slow;
    logic        remote_start, remote_write, remote_done, bus_request_out;
    logic        bus_grant, mem_addr_oe, mem_addr_strobe, upper_address_cycle;
    logic        mem_rd, mem_wr, mem_wdata_oe, port_request, port_read_strobe;
    logic        port_write_strobe, chip_select_n, slave_read_strobe_n, wr_q;
    logic        slave_write_strobe_n, address_latch_strobe_n, mux_addr_mode;
    logic        slave_ack_n, reg_rd_pulse, reg_wr_pulse;
    logic [1:0]  burst_sel;
    logic [3:0]  register_select_lines, reg_index;
    logic [4:0]  fifo_threshold, fifo_level;
    logic [7:0]  remote_start_addr_low, remote_start_addr_high;
    logic [15:0] local_addr, fifo_rdata, fifo_wdata, remote_offset_init;
    logic [15:0] remote_byte_count, remote_addr, remote_count_left, mem_addr;
    logic [15:0] mem_wdata, mem_rdata, port_wdata, port_rdata;
    logic [15:0] wq [$];
    logic [15:0] aq [$];
    int          num_errors = 0, tests_run = 0, seed = 32'hd2e9;
    int          k, n, ups, pr, pw;
    int          blen [2][4] = '{'{2, 4, 8, 12}, '{1, 2, 4, 6}};

    nic_bus_dma #(.FIFO_DEPTH(16), .BUS_DIV(1)) uut (.*);
    bus_partner far_end (.*);

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wrap_up;
        if (num_errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up

    task automatic burst(input bit tf, input bit w, input int b,
                         input bit a32, input bit ab);
        {local_to_fifo, word_mode, addr32_mode} <= {tf, w, a32};
        burst_sel <= b[1:0];
        fifo_level <= tf ? 5'h0 : 5'h10;
        fifo_rdata <= 16'($random(seed));
        local_pending <= 1'b1;
        k = 0;
        while (!bus_request_out && k++ < 100) @(posedge core_clk);
        local_pending <= 1'b0;
        {n, ups} = '0;
        k = 0;
        while (ab && n == 0 && k++ < 100) @(posedge core_clk);
        cut <= ab;
        k = 0;
        while (bus_request_out && k++ < 200) @(posedge core_clk);
        cut <= 1'b0;
        repeat (3) @(posedge core_clk);
        if (ab)
            chk("aborted_burst", 1, n < blen[w][b]);
        else
            chk("burst_len", blen[w][b], n);
        chk("upper_clocks", a32 ? 4 : 0, ups);
    endtask : burst

    task automatic remote(input bit wr, input bit w, input int cnt);
        logic [15:0] off, m, d;
        off = 16'($random(seed)) & 16'hfffe;
        m = w ? 16'hffff : 16'h00ff;
        {remote_write, word_mode, remote_start} <= {wr, w, 1'b1};
        remote_offset_init <= off;
        remote_byte_count <= 16'(cnt);
        @(posedge core_clk);
        remote_start <= 1'b0;
        repeat (w ? cnt / 2 : cnt) begin
            d = 16'($random(seed));
            k = 0;
            while (!port_request && k++ < 100) @(posedge core_clk);
            chk("port_request", 1, port_request);
            if (!wr) chk("port_rdata", (off ^ 16'h5a3c) & m, port_rdata & m);
            if (wr) aq.push_back(off);
            if (wr) wq.push_back(d);
            port_wdata <= d;
            port_write_strobe <= wr;
            port_read_strobe <= !wr;
            @(posedge core_clk);
            {port_write_strobe, port_read_strobe} <= 2'h0;
            repeat (2) @(posedge core_clk);
            chk("port_request_off", 0, port_request);
            if (!wr && off == remote_offset_init) local_pending <= 1'b1;
            off += w ? 16'h2 : 16'h1;
        end
        k = 0;
        while (!remote_done && k++ < 100) @(posedge core_clk);
        chk("remote_done", 1, remote_done);
        chk("count_left", 0, remote_count_left);
        chk("remote_addr", off, remote_addr);
    endtask : remote

    task automatic slave(input bit wr);
        logic [3:0] r;
        r = 4'($random(seed));
        {local_to_fifo, local_pending, fifo_level} <= {2'h3, 5'h0};
        k = 0;
        while (!bus_request_out && k++ < 100) @(posedge core_clk);
        {local_pending, mux_addr_mode} <= {1'b0, wr};
        address_latch_strobe_n <= !wr;
        register_select_lines <= r;
        @(posedge core_clk);
        address_latch_strobe_n <= 1'b1;
        register_select_lines <= wr ? ~r : r;
        {chip_select_n, slave_read_strobe_n, slave_write_strobe_n} <= {1'b0, wr, !wr};
        {pr, pw} = '0;
        k = 0;
        while (slave_ack_n && k++ < 100) @(posedge core_clk);
        chk("busy_at_ack", 0, bus_request_out);
        chk("reg_index", r, reg_index);
        {chip_select_n, slave_read_strobe_n, slave_write_strobe_n} <= 3'h7;
        repeat (6) @(posedge core_clk);
        chk("ack_released", 1, slave_ack_n);
        chk("read_pulses", !wr, pr);
        chk("write_pulses", wr, pw);
    endtask : slave

    always @(posedge core_clk) begin
        n += fifo_push | fifo_pop;
        if (upper_address_cycle) begin
            ups++;
            chk("page", {remote_start_addr_high, remote_start_addr_low}, mem_addr);
        end
        if (fifo_push && word_mode) chk("fifo_wdata", local_addr ^ 16'h5a3c, fifo_wdata);
        if (mem_wr && !remote_write) chk("local_wdata", fifo_rdata, mem_wdata);
        if (local_advance) local_addr <= local_addr + (word_mode ? 16'h2 : 16'h1);
        if (local_advance) local_pending <= 1'b0;
        pr += reg_rd_pulse;
        pw += reg_wr_pulse;
        wr_q <= mem_wr;
        if (mem_wr && !wr_q && remote_write && aq.size() > 0) begin
            chk("mem_addr", aq.pop_front(), mem_addr);
            chk("mem_wdata", wq.pop_front(), mem_wdata);
        end
    end

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    initial begin
        #200000;
        num_errors++;
        wrap_up();
    end

    initial begin
        rst_n = 1'b0;
        {addr32_mode, word_mode, burst_sel, local_pending, wr_q} = '0;
        {local_to_fifo, fifo_level, fifo_rdata, local_addr} = '0;
        {remote_offset_init, remote_byte_count, remote_start} = '0;
        {remote_write, port_wdata, port_read_strobe, port_write_strobe} = '0;
        {mux_addr_mode, slow, cut, register_select_lines} = '0;
        {chip_select_n, slave_read_strobe_n, slave_write_strobe_n} = 3'h7;
        address_latch_strobe_n = 1'b1;
        {remote_start_addr_high, remote_start_addr_low} = 16'($random(seed));
        fifo_threshold = 5'h8;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        {local_to_fifo, local_pending, fifo_level} <= {2'h3, 5'h8};
        repeat (20) @(posedge core_clk);
        chk("held_request", 0, bus_request_out);
        for (int i = 0; i < 16; i++) begin
            slow <= i[0];
            burst(i[3], i[2], i[1:0], i[0] ^ i[3], 1'b0);
        end
        burst(1'b1, 1'b1, 3, 1'b0, 1'b1);
        remote(1'b0, 1'b0, 5);
        remote(1'b1, 1'b1, 6);
        slave(1'b0);
        slave(1'b1);
        wrap_up();
    end
endmodule : nic_bus_dma_tb_top
